// ===== hw/xaui_phy_status_and_control.sv
// Sticky status registers, lane status and power control of a four-lane PHY.
// Assumes one system clock, synchronous inputs and a held request under wait.
`default_nettype none
`include "xaui_phy_status_defines.svh"

module xaui_phy_status_and_control #(
    parameter bit MULTI_QUAD = 1'b0
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic [8:0]  MGMT_ADDR,
    input  wire logic [31:0] MGMT_WRDATA,
    input  wire logic        MGMT_WRITE,
    input  wire logic        MGMT_READ,
    output logic      [31:0] MGMT_RDDATA,
    output logic             MGMT_WAIT,
    input  wire logic [3:0]  RX_SERIAL_IN,
    output logic      [3:0]  RX_LANE_BITS,
    input  wire logic [3:0]  TX_LANE_BITS,
    output logic      [3:0]  TX_SERIAL_OUT,
    input  wire logic [3:0]  RECONFIG_IN,
    output logic      [67:0] RECONFIG_OUT,
    input  wire logic        RX_ANALOG_RESET,
    input  wire logic        RX_DIGITAL_RESET,
    input  wire logic        TX_DIGITAL_RESET,
    input  wire logic        CAL_POWERDOWN,
    input  wire logic        XCVR_POWERDOWN,
    input  wire logic        PLL_POWERDOWN,
    output logic             PLL_LOCKED,
    output logic             CAL_DONE,
    output logic             RX_READY,
    output logic             TX_READY,
    input  wire logic [3:0]  RX_PHASE_ERR_IN,
    input  wire logic [3:0]  RUNLEN_VIOL_IN,
    input  wire logic [7:0]  COL_INS_IN,
    input  wire logic [7:0]  COL_DEL_IN,
    input  wire logic [19:0] RM_FILL_IN,
    input  wire logic [2:0]  TX_PHASE_ERR_IN,
    input  wire logic [3:0]  LANE_ALIGN_IN,
    input  wire logic [7:0]  DISP_ERR_IN,
    input  wire logic [7:0]  CODE_ERR_IN,
    input  wire logic [7:0]  SYNC_IN,
    output logic      [7:0]  COL_INSERTED,
    output logic      [7:0]  COL_DELETED,
    output logic             LANES_ALIGNED,
    output logic      [7:0]  DISP_ERR,
    output logic      [7:0]  CODE_ERR,
    output logic      [7:0]  SYNC_STATUS,
    output logic             SIM_FAST
);
    xaui_phy_status_pkg::top_st_t st_r;
    xaui_phy_status_pkg::top_st_t st_nxt;

    logic        req;
    logic        rd_take;
    logic        wr_take;
    logic [7:0]  rx_flags;
    logic [15:0] col_flags;
    logic [7:0]  lvl_flags;
    logic [2:0]  tx_flags;
    logic [7:0]  lvl_set;
    logic [7:0]  clr_rx;
    logic [15:0] clr_col;
    logic [7:0]  clr_lvl;
    logic [2:0]  clr_tx;

    // ----------------------------------------
    // Management handshake
    // ----------------------------------------
    // Wait for one cycle so read data comes from a flop
    // request held under wait
    assign req       = MGMT_READ | MGMT_WRITE;
    assign MGMT_WAIT = req & ~st_r.ack;
    assign rd_take   = MGMT_READ & st_r.ack;
    assign wr_take   = MGMT_WRITE & st_r.ack;

    assign clr_rx  = (rd_take && MGMT_ADDR == `OFS_RX_PHASE_RUNLEN) ? st_r.rd_data[7:0] : '0;
    assign clr_col = (rd_take && MGMT_ADDR == `OFS_RM_COLUMNS) ? st_r.rd_data[15:0] : '0;
    assign clr_lvl = (rd_take && MGMT_ADDR == `OFS_RM_LEVELS) ? st_r.rd_data[7:0] : '0;
    assign clr_tx  = (rd_take && MGMT_ADDR == `OFS_TX_PHASE) ? st_r.rd_data[2:0] : '0;

    // ----------------------------------------
    // Rate match level per lane
    // ----------------------------------------
    for (genvar l = 0; l < 4; l++)
    begin : g_lane
        assign lvl_set[`FLD_RM_EMPTY_LO + l] = (RM_FILL_IN[5*l +: 5] <= `RM_EMPTY_WORDS);
        assign lvl_set[l] = (RM_FILL_IN[5*l +: 5] >= `RM_FULL_WORDS);
    end

    // ----------------------------------------
    // Sticky flag banks
    // ----------------------------------------
    // sticky lane errors
    sticky_bank #(.W(8)) u_rx_flags (
        .clk   (SYS_CLK),
        .rst   (RST),
        .set   ({RX_PHASE_ERR_IN, RUNLEN_VIOL_IN}),
        .clr   (clr_rx),
        .flags (rx_flags)
    );

    sticky_bank #(.W(16)) u_col_flags (
        .clk   (SYS_CLK),
        .rst   (RST),
        .set   ({COL_INS_IN, COL_DEL_IN}),
        .clr   (clr_col),
        .flags (col_flags)
    );

    sticky_bank #(.W(8)) u_lvl_flags (
        .clk   (SYS_CLK),
        .rst   (RST),
        .set   (lvl_set),
        .clr   (clr_lvl),
        .flags (lvl_flags)
    );

    sticky_bank #(.W(3)) u_tx_flags (
        .clk   (SYS_CLK),
        .rst   (RST),
        .set   (TX_PHASE_ERR_IN),
        .clr   (clr_tx),
        .flags (tx_flags)
    );

    // ----------------------------------------
    // Power, lock and readiness
    // ----------------------------------------
    pma_power_ctrl u_pma (
        .clk            (SYS_CLK),
        .rst            (RST),
        .sim_fast       (st_r.sim_fast),
        .cal_pd         (CAL_POWERDOWN),
        .xcvr_pd        (XCVR_POWERDOWN),
        .pll_pd         (PLL_POWERDOWN),
        .rx_analog_rst  (RX_ANALOG_RESET),
        .rx_digital_rst (RX_DIGITAL_RESET),
        .tx_digital_rst (TX_DIGITAL_RESET),
        .pll_locked     (PLL_LOCKED),
        .cal_done       (CAL_DONE),
        .rx_ready       (RX_READY),
        .tx_ready       (TX_READY)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.ack = req & ~st_r.ack;
        if (req && !st_r.ack)
        begin
            case (MGMT_ADDR)
                `OFS_RX_PHASE_RUNLEN: st_nxt.rd_data = {24'h000000, rx_flags};
                `OFS_RM_COLUMNS:      st_nxt.rd_data = {16'h0000, col_flags};
                `OFS_RM_LEVELS:       st_nxt.rd_data = {24'h000000, lvl_flags};
                `OFS_TX_PHASE:        st_nxt.rd_data = {29'h00000000, tx_flags};
                `OFS_SIM_CTRL:        st_nxt.rd_data = {31'h00000000, st_r.sim_fast};
                default:              st_nxt.rd_data = 32'h00000000;
            endcase
        end
        if (wr_take && MGMT_ADDR == `OFS_SIM_CTRL)
            st_nxt.sim_fast = MGMT_WRDATA[`FLD_SIM_FAST];
        st_nxt.rx_ser = (RX_ANALOG_RESET || XCVR_POWERDOWN) ? 4'h0 : RX_SERIAL_IN;
        st_nxt.tx_ser = (TX_DIGITAL_RESET || XCVR_POWERDOWN) ? 4'h0 : TX_LANE_BITS;
        if (RX_DIGITAL_RESET || XCVR_POWERDOWN)
        begin
            st_nxt.col_ins = 8'h00;
            st_nxt.col_del = 8'h00;
            st_nxt.disp    = 8'h00;
            st_nxt.code    = 8'h00;
            st_nxt.sync    = 8'h00;
            st_nxt.aligned = 1'b0;
        end
        else
        begin
            st_nxt.col_ins = COL_INS_IN;
            st_nxt.col_del = COL_DEL_IN;
            st_nxt.disp    = DISP_ERR_IN;
            st_nxt.code    = CODE_ERR_IN | DISP_ERR_IN;
            st_nxt.sync    = SYNC_IN;
            st_nxt.aligned = &LANE_ALIGN_IN;
        end
        st_nxt.reconf = MULTI_QUAD ? {CAL_DONE, PLL_LOCKED, RX_READY, TX_READY,
                                      RECONFIG_IN, st_r.aligned, st_r.sync}
                                   : 17'h00000;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            st_r <= '{sim_fast: `RST_SIM_FAST, default: '0};
        else
            st_r <= st_nxt;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign MGMT_RDDATA   = st_r.rd_data;
    assign RX_LANE_BITS  = st_r.rx_ser;
    assign TX_SERIAL_OUT = st_r.tx_ser;
    assign RECONFIG_OUT  = {51'h0000000000000, st_r.reconf};
    assign COL_INSERTED  = st_r.col_ins;
    assign COL_DELETED   = st_r.col_del;
    assign LANES_ALIGNED = st_r.aligned;
    assign DISP_ERR      = st_r.disp;
    assign CODE_ERR      = st_r.code;
    assign SYNC_STATUS   = st_r.sync;
    assign SIM_FAST      = st_r.sim_fast;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    a_rx_phase_sticky: assert property (
        (RX_PHASE_ERR_IN != 4'h0) |=> ((rx_flags[7:4] & $past(RX_PHASE_ERR_IN))
                                       == $past(RX_PHASE_ERR_IN)))
        else $error("RX phase error flag not latched");

    a_runlen_read_clear: assert property (
        (rd_take && MGMT_ADDR == `OFS_RX_PHASE_RUNLEN && RUNLEN_VIOL_IN == 4'h0)
        |=> ((rx_flags[3:0] & $past(st_r.rd_data[3:0])) == 4'h0))
        else $error("Run-length flags not cleared by read");

    a_ins_pulse_latch: assert property (
        (COL_INS_IN != 8'h00 && !RX_DIGITAL_RESET && !XCVR_POWERDOWN)
        |=> (COL_INSERTED == $past(COL_INS_IN))
            && ((col_flags[15:8] & $past(COL_INS_IN)) == $past(COL_INS_IN)))
        else $error("Inserted column pulse or latch wrong");

    a_del_latch_hold: assert property (
        (col_flags[0] && !(rd_take && MGMT_ADDR == `OFS_RM_COLUMNS)) |=> col_flags[0])
        else $error("Deleted column flag lost without read");

    a_rm_empty_set: assert property (
        (RM_FILL_IN[4:0] == `RM_EMPTY_WORDS) |=> lvl_flags[`FLD_RM_EMPTY_LO])
        else $error("Empty flag not set at five words");

    a_rm_full_set: assert property (
        (RM_FILL_IN[19:15] == `RM_FULL_WORDS) |=> lvl_flags[3])
        else $error("Full flag not set at twenty words");

    a_tx_phase_sticky: assert property (
        (TX_PHASE_ERR_IN[2] && rd_take) |=> tx_flags[2])
        else $error("TX phase event lost during read");

    a_sim_bit_write: assert property (
        (wr_take && MGMT_ADDR == `OFS_SIM_CTRL) |=> (SIM_FAST == $past(MGMT_WRDATA[0])))
        else $error("Simulation bit not written");

    a_reconf_upper_zero: assert property (
        RECONFIG_OUT[67:17] == 51'h0000000000000)
        else $error("Reconfiguration upper bits not zero");

    a_align_all_lanes: assert property (
        LANES_ALIGNED |-> $past(&LANE_ALIGN_IN))
        else $error("Aligned without all four lanes");

    a_disp_implies_code: assert property (
        (DISP_ERR & ~CODE_ERR) == 8'h00)
        else $error("Disparity error without code error");

    a_pll_pd_unlock: assert property (
        PLL_POWERDOWN |=> !PLL_LOCKED ##1 !TX_READY)
        else $error("PLL locked while powered down");

    a_read_wait_once: assert property (
        (req && !st_r.ack) |-> MGMT_WAIT ##1 !MGMT_WAIT)
        else $error("Wait not exactly one cycle");

    a_reserved_zero: assert property (
        (rd_take && MGMT_ADDR == `OFS_TX_PHASE) |-> (MGMT_RDDATA[31:3] == 29'h00000000))
        else $error("Reserved bits read nonzero");

    c_flag_read_clear: cover property (rd_take && MGMT_RDDATA != 32'h00000000);
    c_set_during_clear: cover property (rd_take && RX_PHASE_ERR_IN != 4'h0);
    c_rx_ready_rise: cover property ($rose(RX_READY));
    c_sim_fast_set: cover property ($rose(SIM_FAST));
endmodule : xaui_phy_status_and_control

`default_nettype wire

// ===== hw/xaui_phy_status_defines.svh
// Offsets, field positions, reset values and timing counts of the PHY status block.
// Assumes a 20 MHz system clock and 9-bit word addresses on the management port.
`ifndef XAUI_PHY_STATUS_DEFINES_SVH
`define XAUI_PHY_STATUS_DEFINES_SVH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define OFS_RX_PHASE_RUNLEN 9'h086
`define OFS_RM_COLUMNS      9'h087
`define OFS_RM_LEVELS       9'h088
`define OFS_TX_PHASE        9'h089
`define OFS_SIM_CTRL        9'h08A

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FLD_RX_PHASE_LO     4
`define FLD_COL_INS_LO      8
`define FLD_RM_EMPTY_LO     4
`define FLD_SIM_FAST        0
`define RST_FLAGS           1'b0
`define RST_SIM_FAST        1'b0
`define RECONF_USED_W       17

// ----------------------------------------
// Rate match fill thresholds
// ----------------------------------------
`define RM_EMPTY_WORDS      5'h05
`define RM_FULL_WORDS       5'h14

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS       50
`define PLL_LOCK_TIME_NS    10000
`define SIM_LOCK_TIME_NS    500
`define CAL_TIME_NS         5000
`define SIM_CAL_TIME_NS     250
`define PLL_LOCK_CYC ((`PLL_LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SIM_LOCK_CYC ((`SIM_LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAL_CYC      ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SIM_CAL_CYC  ((`SIM_CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/xaui_phy_status_pkg.sv
// Types shared by the PHY status block and its helpers.
// Assumes the defines header is compiled alongside.
`default_nettype none

package xaui_phy_status_pkg;
    typedef logic [11:0] count_t;
    typedef enum logic [1:0] {CAL_OFF, CAL_RUN, CAL_READY} cal_state_t;

    typedef struct packed {
        cal_state_t cal;
        count_t     cal_cnt;
        count_t     lock_cnt;
        logic       locked;
        logic       cal_pd_prev;
        logic       rx_ready;
        logic       tx_ready;
    } pma_st_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rd_data;
        logic        sim_fast;
        logic [3:0]  rx_ser;
        logic [3:0]  tx_ser;
        logic [7:0]  col_ins;
        logic [7:0]  col_del;
        logic [7:0]  disp;
        logic [7:0]  code;
        logic [7:0]  sync;
        logic        aligned;
        logic [16:0] reconf;
    } top_st_t;
endpackage : xaui_phy_status_pkg

`default_nettype wire

// ===== hw/sticky_bank.sv
// Bank of sticky flags, set by hardware events, cleared by a read mask.
// Assumes set and clear are synchronous to the system clock.
`default_nettype none
`include "xaui_phy_status_defines.svh"

module sticky_bank #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] flags;
    } sticky_st_t;

    sticky_st_t   st_r;
    sticky_st_t   st_nxt;
    logic [W-1:0] bit_nxt;

    // ----------------------------------------
    // Per-bit update
    // ----------------------------------------
    // set beats clear
    for (genvar g = 0; g < W; g++)
    begin : g_bit
        assign bit_nxt[g] = set[g] | (st_r.flags[g] & ~clr[g]);
    end

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.flags = bit_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_r <= '{flags: {W{`RST_FLAGS}}};
        else
            st_r <= st_nxt;
    end

    assign flags = st_r.flags;
endmodule : sticky_bank

`default_nettype wire

// ===== hw/pma_power_ctrl.sv
// PLL lock, calibration and readiness sequencing of the transceiver.
// Assumes power and reset inputs are synchronous to the system clock.
`default_nettype none
`include "xaui_phy_status_defines.svh"

module pma_power_ctrl (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sim_fast,
    input  wire logic cal_pd,
    input  wire logic xcvr_pd,
    input  wire logic pll_pd,
    input  wire logic rx_analog_rst,
    input  wire logic rx_digital_rst,
    input  wire logic tx_digital_rst,
    output logic      pll_locked,
    output logic      cal_done,
    output logic      rx_ready,
    output logic      tx_ready
);
    xaui_phy_status_pkg::pma_st_t st_r;
    xaui_phy_status_pkg::pma_st_t st_nxt;
    xaui_phy_status_pkg::count_t  lock_len;
    xaui_phy_status_pkg::count_t  cal_len;

    assign lock_len = sim_fast ? xaui_phy_status_pkg::count_t'(`SIM_LOCK_CYC)
                               : xaui_phy_status_pkg::count_t'(`PLL_LOCK_CYC);
    assign cal_len  = sim_fast ? xaui_phy_status_pkg::count_t'(`SIM_CAL_CYC)
                               : xaui_phy_status_pkg::count_t'(`CAL_CYC);

    always_comb
    begin
        st_nxt             = st_r;
        st_nxt.cal_pd_prev = cal_pd;
        if (pll_pd || xcvr_pd)
        begin
            st_nxt.lock_cnt = '0;
            st_nxt.locked   = 1'b0;
        end
        // Ordered compare: the length may shrink mid-count
        else if (st_r.lock_cnt < lock_len)
            st_nxt.lock_cnt = st_r.lock_cnt + 12'h001;
        else
            st_nxt.locked = 1'b1;
        case (st_r.cal)
            xaui_phy_status_pkg::CAL_OFF:
            begin
                if (!cal_pd && !xcvr_pd)
                begin
                    st_nxt.cal     = xaui_phy_status_pkg::CAL_RUN;
                    st_nxt.cal_cnt = '0;
                end
            end
            xaui_phy_status_pkg::CAL_RUN:
            begin
                if (st_r.cal_cnt >= cal_len)
                    st_nxt.cal = xaui_phy_status_pkg::CAL_READY;
                else
                    st_nxt.cal_cnt = st_r.cal_cnt + 12'h001;
            end
            xaui_phy_status_pkg::CAL_READY:
                st_nxt.cal = xaui_phy_status_pkg::CAL_READY;
            default:
                st_nxt.cal = xaui_phy_status_pkg::CAL_OFF;
        endcase
        if (cal_pd || xcvr_pd)
            st_nxt.cal = xaui_phy_status_pkg::CAL_OFF;
        else if (st_r.cal_pd_prev)
        begin
            st_nxt.cal     = xaui_phy_status_pkg::CAL_RUN;
            st_nxt.cal_cnt = '0;
        end
        st_nxt.rx_ready = st_r.locked && (st_r.cal == xaui_phy_status_pkg::CAL_READY)
                          && !rx_analog_rst && !rx_digital_rst && !xcvr_pd;
        st_nxt.tx_ready = st_r.locked && !tx_digital_rst && !xcvr_pd;
        if (xcvr_pd)
        begin
            st_nxt.rx_ready = 1'b0;
            st_nxt.tx_ready = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= '{cal: xaui_phy_status_pkg::CAL_OFF, cal_cnt: 12'h000,
                      lock_cnt: 12'h000, locked: 1'b0, cal_pd_prev: 1'b1,
                      rx_ready: 1'b0, tx_ready: 1'b0};
        end
        else
            st_r <= st_nxt;
    end

    assign pll_locked = st_r.locked;
    assign cal_done   = (st_r.cal == xaui_phy_status_pkg::CAL_READY);
    assign rx_ready   = st_r.rx_ready;
    assign tx_ready   = st_r.tx_ready;
endmodule : pma_power_ctrl

`default_nettype wire

// ===== verification/remote_xcvr.sv
// Remote transceiver model facing the four serial lanes.
// Assumes the system clock stands in for the recovered bit clock.
`default_nettype none
module remote_xcvr (
    input  wire logic       clk,
    input  wire logic [3:0] from_dut,
    output logic      [3:0] to_dut
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] lane_r = 4'hA;

    assign to_dut = lane_r;
    always @(posedge clk)
        lane_r <= (lane_r + 4'h5) ^ from_dut;
endmodule : remote_xcvr
`default_nettype wire

// ===== verification/xaui_phy_status_and_control_tb.sv
// Self-checking bench of the PHY status and control block.
// Assumes design files and the remote lane model compile first.
`default_nettype none
module xaui_phy_status_and_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, wr, rd, wt, algn, plk, cdn, rxr, txr, sf;
    logic        rxa, rxd, txd, calpd, xpd, pllpd;
    logic [8:0]  adr;
    logic [31:0] wd, rdd, v, x;
    logic [3:0]  rser, rlb, tlb, tser, rxe, rlv, lal, rcf, r;
    logic [2:0]  txe;
    logic [7:0]  ci, cd, cio, cdo, de, ce, sy, deo, ceo, syo;
    logic [19:0] fill;
    logic [67:0] rco;
    int          error_cnt, tests_run, cyc, i;

    xaui_phy_status_and_control uut (.SYS_CLK(clk), .RST(rst), .MGMT_ADDR(adr),
        .MGMT_WRDATA(wd), .MGMT_WRITE(wr), .MGMT_READ(rd), .MGMT_RDDATA(rdd),
        .MGMT_WAIT(wt), .RX_SERIAL_IN(rser), .RX_LANE_BITS(rlb), .TX_LANE_BITS(tlb),
        .TX_SERIAL_OUT(tser), .RECONFIG_IN(rcf), .RECONFIG_OUT(rco), .RX_ANALOG_RESET(rxa),
        .RX_DIGITAL_RESET(rxd), .TX_DIGITAL_RESET(txd), .CAL_POWERDOWN(calpd),
        .XCVR_POWERDOWN(xpd), .PLL_POWERDOWN(pllpd), .PLL_LOCKED(plk), .CAL_DONE(cdn),
        .RX_READY(rxr), .TX_READY(txr), .RX_PHASE_ERR_IN(rxe), .RUNLEN_VIOL_IN(rlv),
        .COL_INS_IN(ci), .COL_DEL_IN(cd), .RM_FILL_IN(fill), .TX_PHASE_ERR_IN(txe),
        .LANE_ALIGN_IN(lal), .DISP_ERR_IN(de), .CODE_ERR_IN(ce), .SYNC_IN(sy),
        .COL_INSERTED(cio), .COL_DELETED(cdo), .LANES_ALIGNED(algn), .DISP_ERR(deo),
        .CODE_ERR(ceo), .SYNC_STATUS(syo), .SIM_FAST(sf));
    remote_xcvr peer (.clk(clk), .from_dut(tser), .to_dut(rser));

    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        #1;
        chk({31'h0, wt}, 32'h1);
        for (int n = 0; n < 8; n++)
        begin
            @(posedge clk);
            #1;
            if (!wt)
                break;
        end
        v = rdd;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rc(input logic [8:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(v, exp);
    endtask : rc
    task automatic await(ref logic s, input logic lv, input int n);
        for (int k = 0; k < n && s !== lv; k++)
        begin
            @(posedge clk);
            #1;
        end
        chk({31'h0, s}, {31'h0, lv});
    endtask : await

    // one clock stands in for the reference
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, far above the expected run of about 290 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            conclude();
        end
    end

    initial
    begin
        {wr, rd, rxa, rxd, txd, calpd, xpd, pllpd, adr, wd, tlb, rcf} = '0;
        {rxe, rlv, ci, cd, txe, lal, de, ce, sy} = '0;
        fill = {4{5'h0C}};
        rst = 1'b1;
        void'($urandom(26580));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rc(9'h086, 32'h0);
        bus(1'b1, 9'h08A, 32'hFFFFFFFF);
        rc(9'h08A, 32'h1);
        chk({31'h0, sf}, 32'h1);
        bus(1'b1, 9'h086, 32'hFF);
        rc(9'h086, 32'h0);
        rc(9'h0C0, 32'h0);
        await(plk, 1'b1, 400);
        await(rxr, 1'b1, 200);
        await(txr, 1'b1, 4);
        pllpd <= 1'b1;
        await(plk, 1'b0, 4);
        pllpd <= 1'b0;
        await(plk, 1'b1, 15);
        calpd <= 1'b1;
        await(cdn, 1'b0, 4);
        calpd <= 1'b0;
        await(cdn, 1'b1, 12);
        await(rxr, 1'b1, 4);
        rxd <= 1'b1;
        await(rxr, 1'b0, 4);
        chk({31'h0, txr}, 32'h1);
        rxd <= 1'b0;
        xpd <= 1'b1;
        await(txr, 1'b0, 4);
        xpd <= 1'b0;
        await(rxr, 1'b1, 200);
        chk({31'h0, |rco}, 32'h0);
        // Random traffic on all event and status inputs except the fill levels
        for (i = 0; i < 8; i++)
        begin
            x = $urandom();
            @(posedge clk);
            {rcf, txe, cd, ci, rlv, rxe} <= x[30:0];
            tlb <= x[3:0];
            lal <= i[0] ? 4'hF : x[3:0];
            {sy, ce, de} <= x[23:0];
            #1;
            r = rser;
            @(posedge clk);
            {rxe, rlv, ci, cd, txe} <= '0;
            #1;
            chk(rlb, r);
            chk(tser, x[3:0]);
            chk(cio, x[15:8]);
            chk(cdo, x[23:16]);
            chk(algn, i[0] ? 1'b1 : &x[3:0]);
            chk(deo, x[7:0]);
            chk(ceo, x[15:8] | x[7:0]);
            chk(syo, x[23:16]);
            @(posedge clk);
            #1;
            chk(cio, 8'h00);
            rc(9'h086, {24'h0, x[3:0], x[7:4]});
            rc(9'h087, {16'h0, x[15:8], x[23:16]});
            rc(9'h089, {29'h0, x[26:24]});
            for (int k = 6; k < 10; k++)
                rc(9'h080 + 9'(k), 32'h0);
        end
        fill <= {5'h14, 5'h04, 5'h15, 5'h05};
        @(posedge clk);
        fill <= {4{5'h0C}};
        rc(9'h088, 32'h5A);
        rc(9'h088, 32'h0);
        rlv <= 4'h1;
        txe <= 3'h4;
        rc(9'h086, 32'h1);
        rc(9'h089, 32'h4);
        rlv <= 4'h0;
        txe <= 3'h0;
        rc(9'h086, 32'h1);
        rc(9'h089, 32'h4);
        rc(9'h086, 32'h0);
        rc(9'h089, 32'h0);
        // Mid-run reset returns the control bit to zero
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({31'h0, sf}, 32'h0);
        rc(9'h08A, 32'h0);
        conclude();
    end
endmodule : xaui_phy_status_and_control_tb
`default_nettype wire
